// [core/rst_ctrl_pkg.sv]
// constants and carrier types for the reset entry, exit and boot select block
// ============================================================
// Overview of operation
// R1 - while in reset the core is halted and fetches nothing
// R2 - reset loads register defaults; power-on-only bits are kept otherwise
// R3 - interrupts and timers are disabled on reset entry
// R4 - data RAM is never written or cleared by any reset
// R5 - during reset port latches read 1 and outputs are open-drain
// R6 - weak pull-ups are on during reset and stay on afterwards
// R7 - power-on or supply-monitor reset drives the reset pin low until exit
// R8 - on exit the program counter clears and internal oscillator is selected
// R9 - on exit the watchdog is enabled and running
// R10 - fetch starts at 0x0000 unless the bootloader path applies
// R11 - eight reset causes: por, pin, comparator, software, supply, wdt, clock, flash
// R12 - signature byte before lock byte; bootloader present only when it is 0xa5
// R13 - any other signature value means no bootloader
// R14 - valid signature: start at the bootloader vector after every reset
// R15 - invalid signature: start at 0x0000 after every reset
// R16 - bootloader lives in the last flash page, erasable when unneeded
// R17 - production should clear the signature and lock flash for security
// R18 - a watchdog reset leaves the reset pin alone
// R19 - stay in reset while any source is high; exit synchronised to the clock
package rst_ctrl_pkg;

  // ============================================================
  // widths and fixed values
  localparam int        ADDR_W         = 16;
  localparam int        NUM_SRC        = 8;
  localparam logic [7:0] BOOT_SIG_VALID = 8'ha5;
  localparam logic [15:0] RESET_VECTOR   = 16'h0000;
  localparam logic [15:0] BOOT_VECTOR_DEF = 16'h1e00;  // plain default, top parameter
  localparam logic [15:0] LOCK_ADDR_DEF   = 16'h1fff;  // plain default, top parameter
  localparam logic [1:0] CLK_SEL_INTOSC  = 2'h0;
  localparam logic       PORT_LATCH_RST  = 1'b1;

  // ============================================================
  // cause bit positions
  localparam int SRC_POR  = 0;
  localparam int SRC_PIN  = 1;
  localparam int SRC_CMP  = 2;
  localparam int SRC_SW   = 3;
  localparam int SRC_VMON = 4;
  localparam int SRC_WDT  = 5;
  localparam int SRC_MCD  = 6;
  localparam int SRC_FLSH = 7;

  typedef struct packed {
    logic flash_err;
    logic missing_clk;
    logic watchdog;
    logic supply_mon;
    logic software;
    logic comparator;
    logic pin;
    logic power_on;
  } rst_src_t;

  // controls handed to the rest of the device
  typedef struct packed {
    logic        core_halt;
    logic        reg_init;
    logic        por_reg_init;
    logic        irq_timer_off;
    logic        port_force;
    logic        pullup_en;
    logic        wdt_force_on;
    logic        pc_load;
    logic [15:0] pc_value;
    logic [1:0]  clk_sel;
  } rst_ctl_t;

endpackage

// [core/rst_sync.sv]
// two-flop synchroniser bank for asynchronous reset causes
`timescale 1ns/100ps
`default_nettype none
module rst_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

// [core/rst_ctrl.sv]
// reset entry, exit and boot vector selection
`timescale 1ns/100ps
`default_nettype none
module rst_ctrl #(
  parameter logic [15:0] BOOT_VECTOR = rst_ctrl_pkg::BOOT_VECTOR_DEF,
  parameter logic [15:0] LOCK_ADDR   = rst_ctrl_pkg::LOCK_ADDR_DEF
) (
  input  wire logic                  REF_CLK,
  input  wire logic                  RESET,
  input  wire rst_ctrl_pkg::rst_src_t SRC_IN,
  input  wire logic                  PIN_RESET_N_IN,
  output logic                       PIN_RESET_N_OUT,
  output logic                       PIN_RESET_N_OE,
  output logic [15:0]                SIG_ADDR,
  input  wire logic [7:0]            SIG_DATA,
  output rst_ctrl_pkg::rst_ctl_t     CTL,
  output logic                       IN_RESET,
  output logic [7:0]                 LAST_CAUSE,
  output logic                       BOOT_PRESENT,
  output logic                       RAM_WRITE_BLOCK
);

  // ============================================================
  // source gathering
  logic [7:0] raw_src;
  logic [7:0] sync_src;
  logic [7:0] live_src;
  logic       any_src;
  logic       drive_src;
  logic       self_drive;
  logic       drive_q;
  logic [1:0] drv_hist_q;

  // external pin is active low and comes in through the bank with the rest
  assign raw_src = {SRC_IN.flash_err, SRC_IN.missing_clk, SRC_IN.watchdog,
                    SRC_IN.supply_mon, SRC_IN.software, SRC_IN.comparator,
                    ~PIN_RESET_N_IN, SRC_IN.power_on}; // R11

  rst_sync #(.W(rst_ctrl_pkg::NUM_SRC)) u_sync (
    .clk (REF_CLK),
    .rst (RESET),
    .d   (raw_src),
    .q   (sync_src)
  );

  // own pin drive reads back as a pin cause; masked until the sync bank has flushed
  // limitation: an outside pin pulse that overlaps our own drive is not seen
  assign self_drive = drive_q | (|drv_hist_q);
  assign live_src   = sync_src & ~(8'(self_drive) << rst_ctrl_pkg::SRC_PIN);

  // power-on also arrives through RESET, treated as a source of its own
  assign any_src   = RESET | (|live_src); // R19
  assign drive_src = sync_src[rst_ctrl_pkg::SRC_POR] | sync_src[rst_ctrl_pkg::SRC_VMON];

  // ============================================================
  // state machine
  typedef enum logic [1:0] {S_HOLD, S_SIG, S_RUN} state_t;
  state_t     state_q, state_d;
  logic       drive_d;
  logic       exit_now;
  logic [7:0] cause_q, cause_d;
  logic       boot_q, boot_d;
  logic       pcld_q;
  logic       por_seen_q;

  // leave reset one clean cycle after all causes are gone, reading the signature
  always_comb begin
    state_d = state_q;
    case (state_q)
      S_HOLD:  state_d = any_src ? S_HOLD : S_SIG; // R19
      S_SIG:   state_d = any_src ? S_HOLD : S_RUN;
      S_RUN:   state_d = any_src ? S_HOLD : S_RUN;
      default: state_d = S_HOLD;
    endcase
  end

  // last held cycle: signature is read and the pin is let go together
  assign exit_now = (state_q == S_SIG) && !any_src; // R19

  // pin drive latches for por or supply reset, dropped on the exit edge so that
  // the pin is never pulled while the core already runs
  assign drive_d = exit_now ? 1'b0 : (drive_q | drive_src | RESET); // R7 R18
  // causes accumulate while held, so a later watchdog does not mask a supply event
  assign cause_d = (state_q == S_RUN) ? ((|live_src) ? live_src : cause_q)
                                      : (cause_q & {8{state_q != S_RUN}}) | live_src;
  function automatic logic sig_ok(input logic [7:0] v);
    sig_ok = (v == rst_ctrl_pkg::BOOT_SIG_VALID);
  endfunction
  assign boot_d = (state_q == S_SIG) ? sig_ok(SIG_DATA) : boot_q; // R12 R13

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      state_q    <= S_HOLD;
      drive_q    <= 1'b1;
      cause_q    <= 8'h01;
      boot_q     <= 1'b0;
      pcld_q     <= 1'b0;
      por_seen_q <= 1'b1;
      drv_hist_q <= 2'b11;
    end else begin
      state_q    <= state_d;
      drive_q    <= drive_d;
      cause_q    <= cause_d;
      boot_q     <= boot_d;
      pcld_q     <= exit_now;
      por_seen_q <= live_src[rst_ctrl_pkg::SRC_POR] | ((state_q == S_RUN) ? 1'b0 : por_seen_q);
      drv_hist_q <= {drv_hist_q[0], drive_q};
    end
  end

  // ============================================================
  // outputs to the rest of the device
  logic in_rst;
  assign in_rst = (state_q != S_RUN);

  // signature sits just below the lock byte in the last page
  assign SIG_ADDR = LOCK_ADDR - 16'h0001; // R12 R16

  assign IN_RESET         = in_rst;
  assign LAST_CAUSE       = cause_q;
  assign BOOT_PRESENT     = boot_q;
  assign PIN_RESET_N_OUT  = 1'b0;
  assign PIN_RESET_N_OE   = drive_q; // R7 R18
  // ram keeps its contents: reset only blocks writes, never clears
  assign RAM_WRITE_BLOCK  = in_rst; // R4

  assign CTL.core_halt     = in_rst;                          // R1
  assign CTL.reg_init      = in_rst;                          // R2
  assign CTL.por_reg_init  = in_rst & por_seen_q;             // R2
  assign CTL.irq_timer_off = in_rst;                          // R3
  assign CTL.port_force    = in_rst;                          // R5
  assign CTL.pullup_en     = 1'b1;                            // R6
  assign CTL.wdt_force_on  = in_rst | pcld_q;                 // R9
  assign CTL.pc_load       = in_rst | pcld_q;                 // R8
  assign CTL.pc_value      = boot_q ? BOOT_VECTOR
                                    : rst_ctrl_pkg::RESET_VECTOR; // R10 R14 R15
  assign CTL.clk_sel       = rst_ctrl_pkg::CLK_SEL_INTOSC;    // R8

  // ============================================================
  // checks
  property p_halt;
    @(posedge REF_CLK) disable iff (RESET)
    any_src |=> CTL.core_halt;
  endproperty
  a_halt: assert property (p_halt) else $error("core ran during reset"); // R1

  property p_stay;
    @(posedge REF_CLK) disable iff (RESET)
    (state_q == S_RUN) && (|live_src) |=> IN_RESET[*2];
  endproperty
  a_stay: assert property (p_stay) else $error("reset too short"); // R19

  property p_exit;
    @(posedge REF_CLK) disable iff (RESET)
    (IN_RESET && !any_src) [*2] |-> ##1 !IN_RESET;
  endproperty
  a_exit: assert property (p_exit) else $error("reset exit missed"); // R19

  property p_pin;
    @(posedge REF_CLK) disable iff (RESET)
    sync_src[rst_ctrl_pkg::SRC_VMON] |=> PIN_RESET_N_OE until !IN_RESET;
  endproperty
  a_pin: assert property (p_pin) else $error("pin released early"); // R7

  property p_wdt_pin;
    @(posedge REF_CLK) disable iff (RESET)
    !IN_RESET && !drive_q && (live_src == 8'h20) |=> !PIN_RESET_N_OE;
  endproperty
  a_wdt_pin: assert property (p_wdt_pin) else $error("watchdog drove pin"); // R18

  property p_pin_off;
    @(posedge REF_CLK) disable iff (RESET)
    !IN_RESET |-> !PIN_RESET_N_OE;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin driven while running"); // R7

  property p_vec;
    @(posedge REF_CLK) disable iff (RESET)
    (state_q == S_SIG) && !any_src |=> CTL.pc_value ==
      (($past(SIG_DATA) == rst_ctrl_pkg::BOOT_SIG_VALID) ? BOOT_VECTOR
                                                         : rst_ctrl_pkg::RESET_VECTOR);
  endproperty
  a_vec: assert property (p_vec) else $error("wrong start vector"); // R14 R15

  property p_boot_hold;
    @(posedge REF_CLK) disable iff (RESET)
    !IN_RESET && !$past(IN_RESET) |-> $stable(BOOT_PRESENT);
  endproperty
  a_boot_hold: assert property (p_boot_hold) else $error("signature changed in run"); // R13

  property p_wdt;
    @(posedge REF_CLK) disable iff (RESET)
    $fell(IN_RESET) |-> CTL.wdt_force_on && CTL.pc_load;
  endproperty
  a_wdt: assert property (p_wdt) else $error("exit pulse missing"); // R8 R9

  // held-state controls follow the reset state, except por init (power-on only) and pull-ups (always on)
  property p_core_run;
    @(posedge REF_CLK) disable iff (RESET)
    !IN_RESET |-> !CTL.core_halt;
  endproperty
  a_core_run: assert property (p_core_run) else $error("core halted while running"); // R1

  property p_init;
    @(posedge REF_CLK) disable iff (RESET)
    IN_RESET |-> CTL.reg_init;
  endproperty
  a_init: assert property (p_init) else $error("register init missing"); // R2

  property p_por_init;
    @(posedge REF_CLK) disable iff (RESET)
    CTL.por_reg_init |-> IN_RESET;
  endproperty
  a_por_init: assert property (p_por_init) else $error("por init outside reset"); // R2

  property p_irq;
    @(posedge REF_CLK) disable iff (RESET)
    IN_RESET |-> CTL.irq_timer_off;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupts left on in reset"); // R3

  property p_ram;
    @(posedge REF_CLK) disable iff (RESET)
    RAM_WRITE_BLOCK == IN_RESET;
  endproperty
  a_ram: assert property (p_ram) else $error("ram guard out of step"); // R4

  property p_ports;
    @(posedge REF_CLK) disable iff (RESET)
    IN_RESET |-> CTL.port_force;
  endproperty
  a_ports: assert property (p_ports) else $error("ports not forced in reset"); // R5

  property p_pullup;
    @(posedge REF_CLK) disable iff (RESET)
    CTL.pullup_en;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-ups dropped"); // R6

  // pin, exit pulse, clock source and watchdog
  property p_pin_low;
    @(posedge REF_CLK) disable iff (RESET)
    PIN_RESET_N_OE |-> !PIN_RESET_N_OUT;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin driven high"); // R7

  property p_self_mask;
    @(posedge REF_CLK) disable iff (RESET)
    $fell(PIN_RESET_N_OE) && (live_src == 8'h00) |=> !IN_RESET;
  endproperty
  a_self_mask: assert property (p_self_mask) else $error("own pin echo re-entered"); // R19

  property p_pc_pulse;
    @(posedge REF_CLK) disable iff (RESET)
    $fell(IN_RESET) |=> IN_RESET || !CTL.pc_load;
  endproperty
  a_pc_pulse: assert property (p_pc_pulse) else $error("pc load too long"); // R8

  property p_clk;
    @(posedge REF_CLK) disable iff (RESET)
    CTL.clk_sel == rst_ctrl_pkg::CLK_SEL_INTOSC;
  endproperty
  a_clk: assert property (p_clk) else $error("clock source not internal"); // R8

  property p_wdt_hold;
    @(posedge REF_CLK) disable iff (RESET)
    IN_RESET |-> CTL.wdt_force_on;
  endproperty
  a_wdt_hold: assert property (p_wdt_hold) else $error("watchdog off in reset"); // R9

  // start vector, signature and cause
  property p_run_vec;
    @(posedge REF_CLK) disable iff (RESET)
    !BOOT_PRESENT |-> CTL.pc_value == rst_ctrl_pkg::RESET_VECTOR;
  endproperty
  a_run_vec: assert property (p_run_vec) else $error("reset vector wrong"); // R10 R15

  property p_boot_vec;
    @(posedge REF_CLK) disable iff (RESET)
    BOOT_PRESENT |-> CTL.pc_value == BOOT_VECTOR;
  endproperty
  a_boot_vec: assert property (p_boot_vec) else $error("boot vector wrong"); // R14

  property p_sig_addr;
    @(posedge REF_CLK) disable iff (RESET)
    SIG_ADDR == LOCK_ADDR - 16'h0001;
  endproperty
  a_sig_addr: assert property (p_sig_addr) else $error("signature address wrong"); // R12 R16

  property p_cause;
    @(posedge REF_CLK) disable iff (RESET)
    $rose(IN_RESET) |-> LAST_CAUSE != 8'h00;
  endproperty
  a_cause: assert property (p_cause) else $error("entry without cause"); // R11

  c_boot: cover property (@(posedge REF_CLK) $fell(IN_RESET) && BOOT_PRESENT);
  c_noboot: cover property (@(posedge REF_CLK) $fell(IN_RESET) && !BOOT_PRESENT);
  c_wdt: cover property (@(posedge REF_CLK) sync_src[rst_ctrl_pkg::SRC_WDT] && !IN_RESET);
  c_pin: cover property (@(posedge REF_CLK) $fell(PIN_RESET_N_OE));
endmodule
`default_nettype wire

// [testbench/flash_pin_model.sv]
// flash signature byte and external reset pin model
`timescale 1ns/100ps
`default_nettype none
module flash_pin_model #(
  parameter logic [15:0] LOCK_ADDR = rst_ctrl_pkg::LOCK_ADDR_DEF
) (
  input  wire logic [15:0] sig_addr,
  input  wire logic [7:0]  sig_value,
  output logic      [7:0]  sig_data,
  input  wire logic        pin_oe,
  input  wire logic        pin_out,
  input  wire logic        ext_drive_n,
  output logic             pin_level
);
  // ============================================================
  // signature byte below the lock byte in the last page; elsewhere the inverse
  assign sig_data  = (sig_addr == LOCK_ADDR - 16'h0001) ? sig_value : ~sig_value;
  // pin has a pull-up, so either party pulling low wins
  assign pin_level = (pin_oe ? pin_out : 1'b1) & ext_drive_n;
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench for reset entry, exit and boot vector selection
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic                   ref_clk = 1'b0;
  logic                   reset   = 1'b1;
  rst_ctrl_pkg::rst_src_t src     = '0;
  logic                   ext_n   = 1'b1;
  logic [7:0]             sig     = 8'h00;
  logic                   pin_lvl, pin_out, pin_oe, in_reset, boot_present, ram_block;
  logic [15:0]            sig_addr;
  logic [7:0]             sig_data, last_cause;
  rst_ctrl_pkg::rst_ctl_t ctl;
  int                     n_errors   = 0;
  int                     num_checks = 0;

  // ============================================================
  // clock, design and partner
  always #50 ref_clk = ~ref_clk;
  rst_ctrl dut_u (.REF_CLK(ref_clk), .RESET(reset), .SRC_IN(src), .PIN_RESET_N_IN(pin_lvl),
    .PIN_RESET_N_OUT(pin_out), .PIN_RESET_N_OE(pin_oe), .SIG_ADDR(sig_addr),
    .SIG_DATA(sig_data), .CTL(ctl), .IN_RESET(in_reset), .LAST_CAUSE(last_cause),
    .BOOT_PRESENT(boot_present), .RAM_WRITE_BLOCK(ram_block));
  flash_pin_model model_u (.sig_addr(sig_addr), .sig_value(sig), .sig_data(sig_data),
    .pin_oe(pin_oe), .pin_out(pin_out), .ext_drive_n(ext_n), .pin_level(pin_lvl));

  // ============================================================
  // compares and timing helpers
  task automatic cmp_bit(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %b", $time, what, got);
    end
  endtask
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // inputs move a fixed 10 ns after the rising edge
  task automatic edges(input int n);
    repeat (n) @(posedge ref_clk);
    #10;
  endtask

  // power-up: reset held, then the first exit
  task automatic test_por();
    edges(16);
    cmp_bit(pin_oe, 1'b1, "oe in reset");
    cmp_bit(ctl.por_reg_init, 1'b1, "por init");
    reset = 1'b0;
    edges(1);
    cmp_bit(in_reset, 1'b1, "still in reset");
    cmp_bit(pin_oe, 1'b1, "oe after release");
    edges(1);
    cmp_bit(in_reset, 1'b0, "exit after power-up");
    cmp_bit(pin_oe, 1'b0, "pin released");
    cmp_word(ctl.pc_value, 16'h0000, "vector");
    cmp_bit(ctl.pc_load, 1'b1, "pc load");
    $display("test_por done");
  endtask

  // one cause: enter, hold, leave, check vector and pin behaviour
  task automatic run_cause(input int idx, input logic exp_oe, input logic [15:0] vec);
    if (idx == rst_ctrl_pkg::SRC_PIN) ext_n = 1'b0;
    else src[idx] = 1'b1;
    edges(3);
    cmp_bit(in_reset, 1'b1, "entry");
    cmp_bit(ctl.core_halt, 1'b1, "core halt");
    cmp_bit(ctl.reg_init, 1'b1, "reg init");
    cmp_bit(ctl.irq_timer_off, 1'b1, "irq timer off");
    cmp_bit(ram_block, 1'b1, "ram untouched");
    cmp_bit(ctl.port_force, 1'b1, "port force");
    cmp_bit(ctl.pullup_en, 1'b1, "pullups in reset");
    cmp_bit(pin_oe, exp_oe, "pin drive");
    cmp_bit(ctl.por_reg_init, idx == rst_ctrl_pkg::SRC_POR, "por-only init");
    edges(3);
    ext_n = 1'b1;
    src   = '0;
    edges(3);
    cmp_bit(in_reset, 1'b1, "held until synced");
    edges(1);
    cmp_bit(in_reset, 1'b0, "exit");
    cmp_bit(pin_oe, 1'b0, "pin after exit");
    cmp_bit(ctl.pc_load, 1'b1, "pc load");
    cmp_word(ctl.pc_value, vec, "start vector");
    cmp_word({14'h0000, ctl.clk_sel}, {14'h0000, rst_ctrl_pkg::CLK_SEL_INTOSC}, "clk");
    cmp_bit(ctl.wdt_force_on, 1'b1, "watchdog on");
    cmp_bit(last_cause[idx], 1'b1, "cause seen");
    cmp_word({8'h00, last_cause}, 16'h0001 << idx, "cause mask");
    cmp_bit(boot_present, vec != 16'h0000, "boot present");
    edges(1);
    cmp_bit(ctl.pc_load, 1'b0, "pc load one cycle");
    cmp_bit(ctl.pullup_en, 1'b1, "pullups after");
    cmp_bit(ctl.core_halt, 1'b0, "core runs");
    edges(2);
  endtask

  // every cause with no bootloader, then valid and near-miss signatures
  task automatic test_causes();
    for (int i = 0; i < rst_ctrl_pkg::NUM_SRC; i++) begin
      run_cause(i, (i == rst_ctrl_pkg::SRC_POR) || (i == rst_ctrl_pkg::SRC_VMON), 16'h0000);
    end
    $display("test_causes done");
  endtask
  task automatic test_boot();
    sig = rst_ctrl_pkg::BOOT_SIG_VALID;
    run_cause(rst_ctrl_pkg::SRC_SW, 1'b0, rst_ctrl_pkg::BOOT_VECTOR_DEF);
    run_cause(rst_ctrl_pkg::SRC_WDT, 1'b0, rst_ctrl_pkg::BOOT_VECTOR_DEF);
    sig = 8'ha4;
    run_cause(rst_ctrl_pkg::SRC_SW, 1'b0, 16'h0000);
    $display("test_boot done");
  endtask

  // power-on again in mid-run: pin pulled, power-on-only bits set once more
  task automatic test_rearm();
    reset = 1'b1;
    edges(2);
    cmp_bit(in_reset, 1'b1, "rearm held");
    cmp_bit(pin_oe, 1'b1, "rearm pin");
    cmp_bit(ctl.por_reg_init, 1'b1, "rearm por init");
    reset = 1'b0;
    edges(1);
    cmp_bit(in_reset, 1'b1, "rearm first edge");
    edges(1);
    cmp_bit(in_reset, 1'b0, "rearm exit");
    cmp_bit(pin_oe, 1'b0, "rearm pin released");
    cmp_word({8'h00, last_cause}, 16'h0001, "rearm cause");
    edges(3);
    cmp_bit(in_reset, 1'b0, "no echo from own pin");
    $display("test_rearm done");
  endtask

  // ============================================================
  // verdict and run control
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    test_por();
    test_causes();
    test_boot();
    test_rearm();
    final_report();
  end
  // about 170 cycles expected; cut off well beyond
  initial begin
    #200000;
    n_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    final_report();
  end
endmodule
`default_nettype wire
